//--- hw/cafc_top.sv
// Module: control registers 5 and 6 of the CAN acceptance filters
// How it works
// - Enable bit gates filter participation in matching
// - Two-bit field picks acceptance mask 0-3
// - Five-bit field picks receive buffer 0-31
// - Lane: enable bit7, mask 6-5, buffer 4-0
// - Register 5 holds filters 20 through 23
// - Register 6 holds filters 24 through 27
// - Selections change only while filter disabled
`default_nettype none
module cafc_top
	import cafc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic      [7:0]  filter_on_bit,
	output logic      [15:0] filter_mask_choice,
	output logic      [39:0] filter_buffer_choice
);
	// ********************************************************
	// Address decode
	// ********************************************************
	logic        hit5;
	logic        hit6;
	logic [63:0] regs;
	logic [31:0] rd_d;
	logic [31:0] rdata_q;

	// Each register is one aligned word, bits all used
	assign hit5 = reg_addr == CAFC_ADDR_CTRL5;
	assign hit6 = reg_addr == CAFC_ADDR_CTRL6;

	// ********************************************************
	// Byte lanes, one per filter
	// ********************************************************
	genvar g;
	generate
		for (g = 0; g < CAFC_NFILT; g++) begin : g_lane
			logic hit;
			// Lanes 0-3 live in register 5, lanes 4-7 in register 6
			if (g < 4) begin : g_r5
				assign hit = hit5;
			end else begin : g_r6
				assign hit = hit6;
			end
			cafc_lane cafc_lane_inst (
				.ref_clk (ref_clk),
				.rst_n   (rst_n),
				.wr      (reg_wr && hit),
				.wdata   (reg_wdata[(g%4)*8 +: 8]),
				.lane_q  (regs[g*8 +: 8])
			);
			// Per-filter outputs toward the match logic
			assign filter_on_bit[g]             = regs[g*8+7];
			assign filter_mask_choice[g*2 +: 2] = regs[g*8+5 +: 2];
			assign filter_buffer_choice[g*5 +: 5] = regs[g*8 +: 5];
		end
	endgenerate

	// ********************************************************
	// Read port
	// ********************************************************
	// Unmapped addresses read zero so software sees a clean map
	assign rd_d = hit5 ? regs[31:0] : hit6 ? regs[63:32] : 32'h00000000;

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rdata_q <= CAFC_CTRL_RESET;
		else
			rdata_q <= reg_rd ? rd_d : 32'h00000000;
	end
	assign reg_rdata = rdata_q;

	// ********************************************************
	// Per-filter views of the outputs
	// ********************************************************
	// Named slices keep the checks close to the register layout;
	// filter 20 sits in the lowest slice of each output port
	logic       filter20_on;
	logic       filter21_on;
	logic       filter22_on;
	logic       filter23_on;
	logic       filter24_on;
	logic       filter25_on;
	logic       filter26_on;
	logic       filter27_on;
	cafc_mask_t filter20_mask_choice;
	cafc_mask_t filter21_mask_choice;
	cafc_mask_t filter22_mask_choice;
	cafc_mask_t filter23_mask_choice;
	cafc_mask_t filter24_mask_choice;
	cafc_mask_t filter25_mask_choice;
	cafc_mask_t filter26_mask_choice;
	cafc_mask_t filter27_mask_choice;
	cafc_buf_t  filter20_buffer_choice;
	cafc_buf_t  filter21_buffer_choice;
	cafc_buf_t  filter22_buffer_choice;
	cafc_buf_t  filter23_buffer_choice;
	cafc_buf_t  filter24_buffer_choice;
	cafc_buf_t  filter25_buffer_choice;
	cafc_buf_t  filter26_buffer_choice;
	cafc_buf_t  filter27_buffer_choice;

	// Enable views, one bit per filter
	assign filter20_on = filter_on_bit[0];
	assign filter21_on = filter_on_bit[1];
	assign filter22_on = filter_on_bit[2];
	assign filter23_on = filter_on_bit[3];
	assign filter24_on = filter_on_bit[4];
	assign filter25_on = filter_on_bit[5];
	assign filter26_on = filter_on_bit[6];
	assign filter27_on = filter_on_bit[7];

	// Mask views, two bits per filter
	assign filter20_mask_choice = filter_mask_choice[1:0];
	assign filter21_mask_choice = filter_mask_choice[3:2];
	assign filter22_mask_choice = filter_mask_choice[5:4];
	assign filter23_mask_choice = filter_mask_choice[7:6];
	assign filter24_mask_choice = filter_mask_choice[9:8];
	assign filter25_mask_choice = filter_mask_choice[11:10];
	assign filter26_mask_choice = filter_mask_choice[13:12];
	assign filter27_mask_choice = filter_mask_choice[15:14];

	// Buffer views, five bits per filter
	assign filter20_buffer_choice = filter_buffer_choice[4:0];
	assign filter21_buffer_choice = filter_buffer_choice[9:5];
	assign filter22_buffer_choice = filter_buffer_choice[14:10];
	assign filter23_buffer_choice = filter_buffer_choice[19:15];
	assign filter24_buffer_choice = filter_buffer_choice[24:20];
	assign filter25_buffer_choice = filter_buffer_choice[29:25];
	assign filter26_buffer_choice = filter_buffer_choice[34:30];
	assign filter27_buffer_choice = filter_buffer_choice[39:35];

	// ********************************************************
	// Checks
	// ********************************************************
	read_data_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_rd && !reg_wr && hit6 |=> reg_rdata == $past(regs[63:32]))
		else $error("register 6 read mismatch");
	f21_mask_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_rd && hit5 |=> reg_rdata[14:13] == $past(filter21_mask_choice))
		else $error("filter 21 mask misplaced");
	off_write_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && hit6 && !filter_on_bit[7] |=>
		filter_buffer_choice[39:35] == $past(reg_wdata[28:24]))
		else $error("filter 27 buffer not stored");
	mask_write_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && hit5 && !filter_on_bit[0] |=>
		filter_mask_choice[1:0] == $past(reg_wdata[6:5]))
		else $error("filter 20 mask not stored");
	// Looked at one edge later, once the flops have seen the reset
	reset_clear_a: assert property (
		@(posedge ref_clk)
		!rst_n |=> regs == 64'h0000000000000000)
		else $error("fields not cleared in reset");

	// ********************************************************
	// Enable checks
	// ********************************************************
	// An enable is written by every write to its register,
	// so software can always stop a running filter
	f20_enable_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && hit5 |=> filter20_on == $past(reg_wdata[7]))
		else $error("filter 20 enable not stored");
	f21_enable_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && hit5 |=> filter21_on == $past(reg_wdata[15]))
		else $error("filter 21 enable not stored");
	f22_enable_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && hit5 |=> filter22_on == $past(reg_wdata[23]))
		else $error("filter 22 enable not stored");
	f23_enable_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && hit5 |=> filter23_on == $past(reg_wdata[31]))
		else $error("filter 23 enable not stored");
	f24_enable_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && hit6 |=> filter24_on == $past(reg_wdata[7]))
		else $error("filter 24 enable not stored");
	f25_enable_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && hit6 |=> filter25_on == $past(reg_wdata[15]))
		else $error("filter 25 enable not stored");
	f26_enable_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && hit6 |=> filter26_on == $past(reg_wdata[23]))
		else $error("filter 26 enable not stored");
	f27_enable_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && hit6 |=> filter27_on == $past(reg_wdata[31]))
		else $error("filter 27 enable not stored");

	// ********************************************************
	// Field store checks
	// ********************************************************
	// The enable seen before the write decides; a write that turns
	// a filter off still leaves its old selection in place
	f20_store_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && hit5 && !filter20_on |=>
		filter20_mask_choice == $past(reg_wdata[6:5]) &&
		filter20_buffer_choice == $past(reg_wdata[4:0]))
		else $error("filter 20 fields not stored");
	f21_store_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && hit5 && !filter21_on |=>
		filter21_mask_choice == $past(reg_wdata[14:13]) &&
		filter21_buffer_choice == $past(reg_wdata[12:8]))
		else $error("filter 21 fields not stored");
	f22_store_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && hit5 && !filter22_on |=>
		filter22_mask_choice == $past(reg_wdata[22:21]) &&
		filter22_buffer_choice == $past(reg_wdata[20:16]))
		else $error("filter 22 fields not stored");
	f23_store_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && hit5 && !filter23_on |=>
		filter23_mask_choice == $past(reg_wdata[30:29]) &&
		filter23_buffer_choice == $past(reg_wdata[28:24]))
		else $error("filter 23 fields not stored");
	f24_store_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && hit6 && !filter24_on |=>
		filter24_mask_choice == $past(reg_wdata[6:5]) &&
		filter24_buffer_choice == $past(reg_wdata[4:0]))
		else $error("filter 24 fields not stored");
	f25_store_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && hit6 && !filter25_on |=>
		filter25_mask_choice == $past(reg_wdata[14:13]) &&
		filter25_buffer_choice == $past(reg_wdata[12:8]))
		else $error("filter 25 fields not stored");
	f26_store_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && hit6 && !filter26_on |=>
		filter26_mask_choice == $past(reg_wdata[22:21]) &&
		filter26_buffer_choice == $past(reg_wdata[20:16]))
		else $error("filter 26 fields not stored");
	f27_store_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && hit6 && !filter27_on |=>
		filter27_mask_choice == $past(reg_wdata[30:29]) &&
		filter27_buffer_choice == $past(reg_wdata[28:24]))
		else $error("filter 27 fields not stored");

	// ********************************************************
	// Field lock checks
	// ********************************************************
	// The match logic may be using a running filter, so its mask and
	// buffer choice must not move under it whatever software writes
	f20_lock_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		filter20_on |=> $stable(filter20_mask_choice) &&
		$stable(filter20_buffer_choice))
		else $error("filter 20 fields moved while enabled");
	f21_lock_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		filter21_on |=> $stable(filter21_mask_choice) &&
		$stable(filter21_buffer_choice))
		else $error("filter 21 fields moved while enabled");
	f22_lock_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		filter22_on |=> $stable(filter22_mask_choice) &&
		$stable(filter22_buffer_choice))
		else $error("filter 22 fields moved while enabled");
	f23_lock_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		filter23_on |=> $stable(filter23_mask_choice) &&
		$stable(filter23_buffer_choice))
		else $error("filter 23 fields moved while enabled");
	f24_lock_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		filter24_on |=> $stable(filter24_mask_choice) &&
		$stable(filter24_buffer_choice))
		else $error("filter 24 fields moved while enabled");
	f25_lock_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		filter25_on |=> $stable(filter25_mask_choice) &&
		$stable(filter25_buffer_choice))
		else $error("filter 25 fields moved while enabled");
	f26_lock_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		filter26_on |=> $stable(filter26_mask_choice) &&
		$stable(filter26_buffer_choice))
		else $error("filter 26 fields moved while enabled");
	f27_lock_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		filter27_on |=> $stable(filter27_mask_choice) &&
		$stable(filter27_buffer_choice))
		else $error("filter 27 fields moved while enabled");
endmodule : cafc_top
`default_nettype wire

//--- hw/cafc_pkg.sv
// Package: constants for the CAN acceptance filter control block
`default_nettype none
package cafc_pkg;
	// ********************************************************
	// Register map
	// ********************************************************
	localparam logic [3:0]  CAFC_ADDR_CTRL5  = 4'h0;
	localparam logic [3:0]  CAFC_ADDR_CTRL6  = 4'h4;
	localparam logic [31:0] CAFC_CTRL_RESET  = 32'h00000000;
	// ********************************************************
	// Field layout inside one byte lane
	// ********************************************************
	localparam int          CAFC_LANE_W      = 8;
	localparam int          CAFC_ON_POS      = 7;
	localparam int          CAFC_MASK_LSB    = 5;
	localparam int          CAFC_MASK_W      = 2;
	localparam int          CAFC_BUF_LSB     = 0;
	localparam int          CAFC_BUF_W       = 5;
	localparam int          CAFC_NFILT       = 8;
	localparam int          CAFC_FIRST_FILT  = 20;
	typedef logic [CAFC_MASK_W-1:0] cafc_mask_t;
	typedef logic [CAFC_BUF_W-1:0]  cafc_buf_t;
endpackage : cafc_pkg
`default_nettype wire

//--- hw/cafc_lane.sv
// Module: one filter's control byte with write protection
`default_nettype none
module cafc_lane
	import cafc_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       wr,
	input  wire logic [7:0] wdata,
	output logic      [7:0] lane_q
);
	logic       on_q;
	cafc_mask_t mask_q;
	cafc_buf_t  buf_q;
	logic       sel_wr;

	// Selection fields only move while the filter is off
	assign sel_wr = wr && !on_q;

	// Enable is always writable so software can stop the filter
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			on_q   <= 1'b0;
			mask_q <= 2'h0;
			buf_q  <= 5'h00;
		end else begin
			if (wr)
				on_q <= wdata[CAFC_ON_POS];
			if (sel_wr) begin
				mask_q <= wdata[CAFC_MASK_LSB +: CAFC_MASK_W];
				buf_q  <= wdata[CAFC_BUF_LSB +: CAFC_BUF_W];
			end
		end
	end

	assign lane_q = {on_q, mask_q, buf_q};

	// ********************************************************
	// Checks
	// ********************************************************
	locked_fields_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		on_q |=> (mask_q == $past(mask_q) && buf_q == $past(buf_q)))
		else $error("selection changed while filter enabled");
	open_write_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(wr && !on_q) |=> (lane_q[6:0] == $past(wdata[6:0])))
		else $error("write to disabled filter not stored");
	enable_write_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		wr |=> (on_q == $past(wdata[7])))
		else $error("enable bit not stored");
endmodule : cafc_lane
`default_nettype wire

//--- dv/tb.sv
// Testbench: register access and field mapping of filter control 5 and 6
`default_nettype none
module tb import cafc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h00000000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [7:0]  filter_on_bit;
	logic [15:0] filter_mask_choice;
	logic [39:0] filter_buffer_choice;
	logic [31:0] m [2];
	int          err_total = 0;
	int          checked = 0;
	cafc_top cafc_top_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .filter_on_bit(filter_on_bit),
		.filter_mask_choice(filter_mask_choice),
		.filter_buffer_choice(filter_buffer_choice));
	// 100 MHz clock
	always #5 ref_clk = ~ref_clk;
	// ********************************************************
	// Bus tasks and comparison
	// ********************************************************
	task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, seen);
			err_total++;
		end
	endtask : chk
	// Strobe stays up on return so writes may follow with no gap
	task automatic wr(logic [3:0] a, logic [31:0] d);
		int r;
		r = (a == CAFC_ADDR_CTRL6) ? 1 : 0;
		if (a == CAFC_ADDR_CTRL5 || a == CAFC_ADDR_CTRL6)
			for (int k = 0; k < 4; k++) begin
				if (!m[r][8*k+7])
					m[r][8*k+:7] = d[8*k+:7];
				m[r][8*k+7] = d[8*k+7];
			end
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(logic [3:0] a, logic [31:0] exp);
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		// Data stood through the last cycle; read before the flop moves
		@(posedge ref_clk);
		chk("reg_rdata", 64'(reg_rdata), 64'(exp));
	endtask : rd
	// Idle one cycle, then compare every filter output with the model
	task automatic outs();
		logic [7:0]  on;
		logic [15:0] mk;
		logic [39:0] bf;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		// Outputs settled at the edge before, so this edge sees them
		@(posedge ref_clk);
		for (int f = 0; f < CAFC_NFILT; f++) begin
			on[f] = m[f/4][8*(f%4)+7];
			mk[2*f+:2] = m[f/4][8*(f%4)+5+:2];
			bf[5*f+:5] = m[f/4][8*(f%4)+:5];
		end
		chk("filter_on_bit", 64'(filter_on_bit), 64'(on));
		chk("filter_mask", 64'(filter_mask_choice), 64'(mk));
		chk("filter_buffer", 64'(filter_buffer_choice), 64'(bf));
	endtask : outs
	task automatic end_sim();
		if (err_total == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	// ********************************************************
	// Tests
	// ********************************************************
	initial begin
		m[0] = CAFC_CTRL_RESET;
		m[1] = CAFC_CTRL_RESET;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		outs();
		rd(CAFC_ADDR_CTRL6, 32'h00000000);
		wr(CAFC_ADDR_CTRL5, 32'hE0403F85);
		wr(CAFC_ADDR_CTRL6, 32'h7F5FA0C3);
		rd(CAFC_ADDR_CTRL5, 32'hE0403F85);
		rd(CAFC_ADDR_CTRL6, 32'h7F5FA0C3);
		outs();
		// Enabled lanes keep fields; second write lands once disabled
		for (int i = 0; i < 2; i++) begin
			wr(CAFC_ADDR_CTRL5, 32'h1F1F1F1F);
			wr(CAFC_ADDR_CTRL6, 32'hFFFFFFFF);
			rd(CAFC_ADDR_CTRL5, m[0]);
			rd(CAFC_ADDR_CTRL6, m[1]);
			outs();
		end
		wr(4'h8, 32'hFFFFFFFF);
		rd(4'h8, 32'h00000000);
		outs();
		// Reset in mid-run clears everything
		rst_n <= 1'b0;
		m[0] = CAFC_CTRL_RESET;
		m[1] = CAFC_CTRL_RESET;
		outs();
		rst_n <= 1'b1;
		rd(CAFC_ADDR_CTRL6, 32'h00000000);
		rd(CAFC_ADDR_CTRL5, 32'h00000000);
		end_sim();
	end
	// Watchdog: tests need well under 200 cycles
	initial begin
		repeat (2000) @(posedge ref_clk);
		err_total++;
		end_sim();
	end
endmodule : tb
`default_nettype wire
